// ### verilog/wwd_pkg.sv
package wwd_pkg;
    // Counter and prescaler geometry
    localparam int CNT_W = 12;
    localparam int PRESC_DIV = 128;
    localparam int PRESC_W = 7;

    // One-time mode register layout and reset value
    localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
    localparam int LOAD_LSB = 0;
    localparam int LOAD_MSB = 11;
    localparam int FIEN_BIT = 12;
    localparam int RSTEN_BIT = 13;
    localparam int RPROC_BIT = 14;
    localparam int DIS_BIT = 15;
    localparam int DELTA_LSB = 16;
    localparam int DELTA_MSB = 27;
    localparam int DBGHLT_BIT = 28;
    localparam int IDLEHLT_BIT = 29;

    // Keyed control register layout
    localparam int KEY_LSB = 24;
    localparam int KEY_MSB = 31;
    localparam logic [7:0] KEY_VALUE = 8'hA5;
    localparam int RESTART_BIT = 0;

    // Status layout
    localparam int UNF_BIT = 0;
    localparam int ERR_BIT = 1;

    // Mode register write lock
    typedef enum logic [1:0] {
        WWD_ST_OPEN = 2'b01,
        WWD_ST_LOCKED = 2'b10
    } wwd_lock_t;

    // Restart permitted while the counter sits at or below delta
    function automatic logic wwd_in_window(input logic [CNT_W-1:0] cnt,
                                           input logic [CNT_W-1:0] delta);
        wwd_in_window = (cnt <= delta);
    endfunction
endpackage

// ### verilog/wwd_presc.sv
module wwd_presc #(
    parameter int DIV = wwd_pkg::PRESC_DIV,
    parameter int W = wwd_pkg::PRESC_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic clear_i,
    input wire logic run_i,
    // Divided tick
    output logic tick_o
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] ONE = W'(1);

    // Count while running, restart on clear, pulse on wrap
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (clear_i) begin
            next_cnt = '0;
        end else if (run_i) begin
            if (cnt == LAST) begin
                next_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + ONE;
            end
        end
    end

    // Divider state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule // wwd_presc

// ### verilog/wwd_top.sv
// Operation
// RL1 - 12-bit down counter loads from the mode register load field.
// RL2 - Counter steps at clock divided by 128.
// RL3 - After reset mode holds load 0xFFF with fault reset enabled.
// RL4 - Software disables the watchdog or reprograms its timeout.
// RL5 - Only the first mode write is taken until the next reset.
// RL6 - The accepted mode write reloads and restarts the counter.
// RL7 - Valid restart reloads counter and restarts the 128 divider.
// RL8 - Control writes with a wrong key are ignored.
// RL9 - Control key in the upper byte must be 0xA5.
// RL10 - Underflow sets sticky flag; fault follows when reset enabled.
// RL11 - Software restarts only with counter between zero and delta.
// RL12 - Restart above delta sets error and fault, even if disabled.
// RL13 - Delta at or above load value accepts restarts everywhere.
// RL14 - Interrupt follows either flag when fault interrupt enabled.
// RL15 - Watchdog reset clears the processor, block and both flags.
// RL16 - Status read or reset clears flags, interrupt and fault.
// RL17 - Counter stops in debug or idle per the halt bits.
// RL18 - Debug halt bit one stops the counter in debug state.
// RL19 - Processor-only select limits the fault to processor reset.
// RL20 - Tick decrements when enabled; tick at zero is underflow.
module wwd_top #(
    parameter int CNT_W = wwd_pkg::CNT_W,
    parameter int PRESC_DIV = wwd_pkg::PRESC_DIV
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // Mode register write and readback
    input wire logic MODE_WR_I,
    input wire logic [31:0] MODE_DATA_I,
    output logic [31:0] MODE_O,
    // Keyed control register write
    input wire logic CTRL_WR_I,
    input wire logic [31:0] CTRL_DATA_I,
    // Status register read
    input wire logic STATUS_RD_I,
    output logic [1:0] STATUS_O,
    // Processor state
    input wire logic DEBUG_I,
    input wire logic IDLE_I,
    // Counter, interrupt and fault
    output logic [CNT_W-1:0] COUNT_O,
    output logic INT_O,
    output logic FAULT_O,
    output logic FAULT_PROC_ONLY_O
);
    logic rst_meta;
    logic rst_sync;
    logic tick;
    logic presc_clear;
    logic presc_run;
    logic [31:0] mode;
    logic [31:0] next_mode;
    wwd_pkg::wwd_lock_t lock_state;
    wwd_pkg::wwd_lock_t next_lock_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic unf_flag;
    logic err_flag;
    logic fault;
    logic irq;
    logic proc_only;
    logic next_unf_flag;
    logic next_err_flag;
    logic next_fault;
    logic next_irq;
    logic next_proc_only;
    logic [CNT_W-1:0] load_val;
    logic [CNT_W-1:0] delta_val;
    logic mode_acc;
    logic key_ok;
    logic restart;
    logic restart_ok;
    logic restart_err;
    logic halted;
    logic enabled;
    logic tick_now;
    logic underflow;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam int GAP_W = wwd_pkg::PRESC_W + 1;
    localparam logic [GAP_W-1:0] GAP_FULL = GAP_W'(PRESC_DIV);
    logic [GAP_W-1:0] run_gap;
    logic [GAP_W-1:0] next_run_gap;

    // Reset release through two flops
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Mode field decode
    assign load_val = mode[wwd_pkg::LOAD_MSB:wwd_pkg::LOAD_LSB]; // [RL1]
    assign delta_val = mode[wwd_pkg::DELTA_MSB:wwd_pkg::DELTA_LSB];
    assign enabled = !mode[wwd_pkg::DIS_BIT];

    // Halt selection from debug and idle
    assign halted = (DEBUG_I && mode[wwd_pkg::DBGHLT_BIT]) // [RL17] [RL18]
        || (IDLE_I && mode[wwd_pkg::IDLEHLT_BIT]); // [RL17]

    // Command decode
    assign mode_acc = MODE_WR_I
        && (lock_state == wwd_pkg::WWD_ST_OPEN); // [RL5]
    assign key_ok = CTRL_DATA_I[wwd_pkg::KEY_MSB:wwd_pkg::KEY_LSB]
        == wwd_pkg::KEY_VALUE; // [RL8] [RL9]
    assign restart = CTRL_WR_I && key_ok
        && CTRL_DATA_I[wwd_pkg::RESTART_BIT];
    assign restart_ok = restart
        && wwd_pkg::wwd_in_window(count, delta_val); // [RL11] [RL13]
    assign restart_err = restart
        && !wwd_pkg::wwd_in_window(count, delta_val); // [RL12]
    assign tick_now = tick && enabled && !halted; // [RL20]
    assign underflow = tick_now && (count == CNT_ZERO)
        && !mode_acc && !restart_ok; // [RL20]

    // Divider restarts on reload, runs only while counting
    assign presc_clear = mode_acc || restart_ok; // [RL7]
    assign presc_run = enabled && !halted; // [RL2] [RL17]

    // Run cycles seen by the divider since its last wrap or clear
    always_comb begin
        next_run_gap = tick ? '0 : run_gap;
        if (presc_clear) begin
            next_run_gap = '0;
        end else if (presc_run) begin
            next_run_gap = next_run_gap + GAP_W'(1);
        end
    end

    // Clock divided by 128
    wwd_presc #(
        .DIV(PRESC_DIV),
        .W(wwd_pkg::PRESC_W)
    ) u_presc (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_sync),
        .clear_i(presc_clear),
        .run_i(presc_run),
        .tick_o(tick)
    );

    // Mode lock and write-once storage
    always_comb begin
        next_mode = mode;
        next_lock_state = lock_state;
        case (lock_state)
            wwd_pkg::WWD_ST_OPEN: begin
                if (MODE_WR_I) begin
                    next_mode = MODE_DATA_I;
                    next_lock_state = wwd_pkg::WWD_ST_LOCKED; // [RL5]
                end
            end
            wwd_pkg::WWD_ST_LOCKED: begin
                next_lock_state = wwd_pkg::WWD_ST_LOCKED; // [RL5]
            end
            default: begin
                next_lock_state = wwd_pkg::WWD_ST_LOCKED;
            end
        endcase
    end

    // Down counter: mode write, then restart, then tick
    always_comb begin
        next_count = count;
        if (mode_acc) begin
            next_count =
                MODE_DATA_I[wwd_pkg::LOAD_MSB:wwd_pkg::LOAD_LSB]; // [RL6]
        end else if (restart_ok) begin
            next_count = load_val; // [RL7]
        end else if (tick_now) begin
            if (count == CNT_ZERO) begin
                next_count = load_val;
            end else begin
                next_count = count - CNT_ONE; // [RL20]
            end
        end
    end

    // Sticky flags, fault and interrupt; a new event beats the read
    always_comb begin
        next_unf_flag = unf_flag;
        next_err_flag = err_flag;
        next_fault = fault;
        next_proc_only = proc_only;
        if (STATUS_RD_I) begin
            next_unf_flag = 1'b0; // [RL16]
            next_err_flag = 1'b0;
            next_fault = 1'b0;
        end
        if (underflow) begin
            next_unf_flag = 1'b1; // [RL10]
            if (mode[wwd_pkg::RSTEN_BIT]) begin
                next_fault = 1'b1; // [RL10]
            end
        end
        if (restart_err) begin
            next_err_flag = 1'b1; // [RL12]
            next_fault = 1'b1; // [RL12]
        end
        if (next_fault && !fault) begin
            next_proc_only = mode[wwd_pkg::RSTEN_BIT]
                && mode[wwd_pkg::RPROC_BIT]; // [RL19]
        end
        next_irq = mode[wwd_pkg::FIEN_BIT]
            && (next_unf_flag || next_err_flag); // [RL14]
    end

    // State registers; any reset restores defaults and clears faults
    always_ff @(posedge CLOCK_I or negedge rst_sync) begin
        if (!rst_sync) begin
            mode <= wwd_pkg::MODE_RESET; // [RL3]
            lock_state <= wwd_pkg::WWD_ST_OPEN;
            count <= wwd_pkg::MODE_RESET[wwd_pkg::LOAD_MSB:wwd_pkg::LOAD_LSB];
            unf_flag <= 1'b0; // [RL15] [RL16]
            err_flag <= 1'b0; // [RL15]
            fault <= 1'b0;
            irq <= 1'b0;
            proc_only <= 1'b0;
            run_gap <= '0;
        end else begin
            mode <= next_mode;
            lock_state <= next_lock_state;
            count <= next_count;
            unf_flag <= next_unf_flag;
            err_flag <= next_err_flag;
            fault <= next_fault;
            irq <= next_irq;
            proc_only <= next_proc_only;
            run_gap <= next_run_gap;
        end
    end

    // Outputs straight from flops
    assign MODE_O = mode;
    assign COUNT_O = count;
    assign STATUS_O = {err_flag, unf_flag};
    assign INT_O = irq;
    assign FAULT_O = fault;
    assign FAULT_PROC_ONLY_O = proc_only;

    // Reset leaves the default mode in place
    AST_RESET_MODE: assert property (@(posedge CLOCK_I) // [RL3]
        $rose(rst_sync) |-> (mode == wwd_pkg::MODE_RESET) && !fault)
        else $error("mode not at default after reset");

    // Second mode write leaves mode unchanged
    AST_MODE_ONCE: assert property (@(posedge CLOCK_I) // [RL5]
        disable iff (!rst_sync)
        MODE_WR_I && (lock_state == wwd_pkg::WWD_ST_LOCKED)
        |=> $stable(mode))
        else $error("locked mode register changed");

    // Accepted mode write loads the new count
    AST_MODE_RELOAD: assert property (@(posedge CLOCK_I) // [RL6]
        disable iff (!rst_sync)
        mode_acc |=> (count == load_val) && (mode == $past(MODE_DATA_I)))
        else $error("mode write did not reload counter");

    // Good restart reloads and restarts the divider
    AST_RESTART: assert property (@(posedge CLOCK_I) // [RL7]
        disable iff (!rst_sync)
        restart_ok && !mode_acc |=> (count == load_val) && !tick)
        else $error("restart did not reload counter");

    // Wrong key never raises the error flag
    AST_BAD_KEY: assert property (@(posedge CLOCK_I) // [RL8]
        disable iff (!rst_sync)
        CTRL_WR_I && !key_ok && !err_flag |=> !err_flag)
        else $error("unkeyed control write had effect");

    // Underflow sets the flag and, when enabled, the fault
    AST_UNDERFLOW: assert property (@(posedge CLOCK_I) // [RL10]
        disable iff (!rst_sync)
        underflow |=> unf_flag
            && (fault || !$past(mode[wwd_pkg::RSTEN_BIT])))
        else $error("underflow not flagged");

    // Restart outside the window is an error and a fault
    AST_WIN_ERR: assert property (@(posedge CLOCK_I) // [RL12]
        disable iff (!rst_sync)
        restart_err |=> err_flag && fault)
        else $error("window error not flagged");

    // Wide window never raises the error
    AST_WIN_OPEN: assert property (@(posedge CLOCK_I) // [RL13]
        disable iff (!rst_sync)
        restart && (delta_val >= load_val) && (count <= load_val)
        |-> !restart_err)
        else $error("restart refused with open window");

    // Interrupt follows the underflow flag under the enable
    AST_IRQ: assert property (@(posedge CLOCK_I) // [RL14]
        disable iff (!rst_sync)
        $rose(unf_flag) && mode[wwd_pkg::FIEN_BIT] |-> INT_O)
        else $error("interrupt missing on flag");

    // Status read with no new event clears flags, fault and interrupt
    AST_STATUS_CLEAR: assert property (@(posedge CLOCK_I) // [RL16]
        disable iff (!rst_sync)
        STATUS_RD_I && !underflow && !restart_err
        |=> !unf_flag && !err_flag && !fault && !INT_O)
        else $error("status read did not clear");

    // Debug halt freezes the counter
    AST_DEBUG_HALT: assert property (@(posedge CLOCK_I) // [RL18]
        disable iff (!rst_sync)
        DEBUG_I && mode[wwd_pkg::DBGHLT_BIT] && !mode_acc && !restart_ok
        |=> $stable(count))
        else $error("counter moved in debug halt");

    // Processor-only select follows the mode at fault onset
    AST_PROC_ONLY: assert property (@(posedge CLOCK_I) // [RL19]
        disable iff (!rst_sync)
        $rose(fault) |-> FAULT_PROC_ONLY_O == ($past(mode[
            wwd_pkg::RSTEN_BIT]) && $past(mode[wwd_pkg::RPROC_BIT])))
        else $error("fault reset scope wrong");

    // Tick steps the counter down by one
    AST_DECREMENT: assert property (@(posedge CLOCK_I) // [RL20]
        disable iff (!rst_sync)
        tick_now && (count != CNT_ZERO) && !mode_acc && !restart_ok
        |=> count == $past(count) - CNT_ONE)
        else $error("counter did not decrement");

    // Every tick follows one full divider period of run cycles
    AST_DIVIDE: assert property (@(posedge CLOCK_I) // [RL2]
        disable iff (!rst_sync)
        tick |-> run_gap == GAP_FULL)
        else $error("divider period wrong");
endmodule // wwd_top

// ### tb/wwd_rstc_model.sv
module wwd_rstc_model (
    // Clock
    input wire logic clk_i,
    // Fault from the watchdog and answer enable from the bench
    input wire logic fault_i,
    input wire logic answer_en_i,
    // Reset request back into the watchdog
    output logic rst_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Enabled fault answered by a short reset after a settling delay
    initial begin
        rst_n_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (answer_en_i && fault_i === 1'b1) begin
                repeat (4) @(posedge clk_i);
                rst_n_o <= 1'b0;
                repeat (3) @(posedge clk_i);
                rst_n_o <= 1'b1;
            end
        end
    end
endmodule // wwd_rstc_model

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    logic CLOCK_I = 1'b0;
    logic rst_n = 1'b0;
    logic answer_en = 1'b0;
    logic model_rst_n;
    logic MODE_WR_I = 1'b0;
    logic CTRL_WR_I = 1'b0;
    logic STATUS_RD_I = 1'b0;
    logic DEBUG_I = 1'b0;
    logic IDLE_I = 1'b0;
    logic [31:0] MODE_DATA_I = 32'h0;
    logic [31:0] CTRL_DATA_I = 32'h0;
    logic [31:0] MODE_O;
    logic [1:0] STATUS_O;
    logic [11:0] COUNT_O;
    logic INT_O;
    logic FAULT_O;
    logic FAULT_PROC_ONLY_O;
    int n_errors = 0;
    int check_count = 0;
    logic [11:0] L, D, c;
    logic [31:0] m;
    logic [7:0] k;
    logic rp;

    wwd_top #(.PRESC_DIV(DIV)) dut (
        .CLOCK_I(CLOCK_I), .RST_N_I(rst_n & model_rst_n),
        .MODE_WR_I(MODE_WR_I), .MODE_DATA_I(MODE_DATA_I), .MODE_O(MODE_O),
        .CTRL_WR_I(CTRL_WR_I), .CTRL_DATA_I(CTRL_DATA_I),
        .STATUS_RD_I(STATUS_RD_I), .STATUS_O(STATUS_O),
        .DEBUG_I(DEBUG_I), .IDLE_I(IDLE_I), .COUNT_O(COUNT_O),
        .INT_O(INT_O), .FAULT_O(FAULT_O),
        .FAULT_PROC_ONLY_O(FAULT_PROC_ONLY_O)
    );

    wwd_rstc_model rstc (
        .clk_i(CLOCK_I), .fault_i(FAULT_O), .answer_en_i(answer_en),
        .rst_n_o(model_rst_n)
    );

    // 40 MHz clock
    initial forever #12.5 CLOCK_I = ~CLOCK_I;

    // Mode word from its fields
    function automatic logic [31:0] mode_word(logic [11:0] ld, logic fi,
        logic re, logic po, logic ds, logic [11:0] dl, logic dh, logic ih);
        mode_word = {2'b00, ih, dh, dl, ds, po, re, fi, ld};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK_I);
        #1;
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask

    // Flags as {status, interrupt, fault, processor only}
    task automatic chk_flags(input logic [4:0] e, input logic [4:0] msk);
        logic [4:0] g;
        g = {STATUS_O, INT_O, FAULT_O, FAULT_PROC_ONLY_O};
        check_count++;
        if (((g ^ e) & msk) !== 5'h00) begin
            n_errors++;
            $display("mismatch at %0t: flags %b expected %b", $time, g, e);
        end
    endtask

    // One-cycle strobe: 0 mode write, 1 control write, 2 status read
    task automatic strobe(input int which, input logic [31:0] d);
        @(posedge CLOCK_I);
        case (which)
            0: begin
                MODE_WR_I <= 1'b1;
                MODE_DATA_I <= d;
            end
            1: begin
                CTRL_WR_I <= 1'b1;
                CTRL_DATA_I <= d;
            end
            default: STATUS_RD_I <= 1'b1;
        endcase
        @(posedge CLOCK_I);
        MODE_WR_I <= 1'b0;
        CTRL_WR_I <= 1'b0;
        STATUS_RD_I <= 1'b0;
        tick(1);
    endtask

    function automatic logic hit(input int kind, input logic [11:0] s);
        case (kind)
            0: hit = (COUNT_O !== s);
            1: hit = (COUNT_O <= D);
            2: hit = (STATUS_O[0] === 1'b1);
            default: hit = (model_rst_n === 1'b0);
        endcase
    endfunction

    // Bounded wait for a count change, window, underflow or reset
    task automatic wait_for(input int kind);
        logic [11:0] s;
        int n;
        s = COUNT_O;
        for (n = 0; n < 2000 && !hit(kind, s); n++)
            tick(1);
        if (n == 2000) begin
            n_errors++;
            $display("mismatch at %0t: wait %0d timed out", $time, kind);
        end
    endtask

    // Hang guard
    initial begin
        repeat (30000) @(posedge CLOCK_I);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence
    initial begin
        void'($urandom(63290));
        tick(1);
        chk_word(MODE_O, wwd_pkg::MODE_RESET);
        chk_word(32'(COUNT_O), 32'h0000_0FFF);
        chk_flags(5'h00, 5'h1F);
        @(posedge CLOCK_I);
        rst_n <= 1'b1;
        tick(4);
        // Wrong key, then right key without restart bit
        k = 8'($urandom_range(0, 255));
        if (k == 8'hA5)
            k = 8'h5A;
        for (int i = 0; i < 2; i++) begin
            wait_for(0);
            c = COUNT_O;
            strobe(1, (i == 0) ? {k, 24'h000001} : 32'hA500_0000);
            chk_word(32'(COUNT_O), 32'(c));
        end
        strobe(1, 32'hA500_0001);
        chk_word(32'(COUNT_O), 32'h0000_0FFF);
        chk_flags(5'h00, 5'h1E);
        // One-time mode write with a narrow window
        L = 12'(24 + $urandom_range(0, 31));
        D = 12'($urandom_range(4, 16));
        rp = 1'($urandom_range(0, 1));
        m = mode_word(L, 1'b1, 1'b1, rp, 1'b0, D, 1'b1, 1'b1);
        strobe(0, m);
        chk_word(MODE_O, m);
        chk_word(32'(COUNT_O), 32'(L));
        strobe(0, ~m);
        chk_word(MODE_O, m);
        // Early restart is a window error
        strobe(1, 32'hA500_0001);
        chk_flags({4'b1001, rp}, 5'h1B);
        tick(1);
        chk_flags({4'b1011, rp}, 5'h1F);
        strobe(2, 32'h0);
        chk_flags(5'h00, 5'h1E);
        // Step every DIV cycles
        wait_for(0);
        c = COUNT_O;
        tick(DIV);
        chk_word(32'(COUNT_O), 32'(c - 12'h001));
        // Debug halt, then idle halt
        for (int i = 0; i < 2; i++) begin
            @(posedge CLOCK_I);
            DEBUG_I <= (i == 0);
            IDLE_I <= (i == 1);
            tick(3);
            c = COUNT_O;
            tick(3 * DIV);
            chk_word(32'(COUNT_O), 32'(c));
        end
        @(posedge CLOCK_I);
        DEBUG_I <= 1'b0;
        IDLE_I <= 1'b0;
        // Restart inside the window
        wait_for(1);
        strobe(1, 32'hA500_0001);
        chk_word(32'(COUNT_O), 32'(L));
        chk_flags(5'h00, 5'h1E);
        // Underflow, then the reset controller answers
        @(posedge CLOCK_I);
        answer_en <= 1'b1;
        wait_for(2);
        tick(1);
        chk_flags({4'b0111, rp}, 5'h1F);
        wait_for(3);
        tick(1);
        chk_word(MODE_O, wwd_pkg::MODE_RESET);
        chk_word(32'(COUNT_O), 32'h0000_0FFF);
        chk_flags(5'h00, 5'h1F);
        @(posedge CLOCK_I);
        answer_en <= 1'b0;
        tick(8);
        // Disabled watchdog: mode writable again, no count, error raised
        L = 12'(24 + $urandom_range(0, 31));
        m = mode_word(L, 1'b0, 1'b0, 1'b0, 1'b1, D, 1'b0, 1'b0);
        strobe(0, m);
        chk_word(MODE_O, m);
        tick(3 * DIV);
        chk_word(32'(COUNT_O), 32'(L));
        strobe(1, 32'hA500_0001);
        tick(1);
        chk_flags(5'h12, 5'h1F);
        final_report();
    end
endmodule // tb
